// File: verilog/flash_cmd_defines.vh
// constants for the wake, identification, secure-region and security-status slice
`ifndef FLASH_CMD_DEFINES_VH
`define FLASH_CMD_DEFINES_VH

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define OP_NONE 8'h00
`define OP_WAKE_SIG 8'hab
`define OP_ID_MAIN 8'h90
`define OP_ID_ALT_A 8'hdf
`define OP_ID_ALT_B 8'hef
`define OP_ENTER_SECURE 8'hb1
`define OP_EXIT_SECURE 8'hc1
`define OP_SEC_READ 8'h2b
`define OP_SEC_WRITE 8'h2f
`define OP_PROT_SELECT 8'h68
`define OP_ENTER_WIDE 8'hb7
`define OP_EXIT_WIDE 8'he9
`define OP_FAIL_CLEAR 8'h30
`define OP_POWER_DOWN 8'hb9

// ----------------------------------------------------------------
// frame bit counts and id address
// ----------------------------------------------------------------
`define BITS_OPCODE 6'h08
`define BITS_ID_HEADER 6'h20
`define BITS_SIG_MIN 6'h28
`define BITS_MAX 6'h3f
`define ID_SWAP_ADDR 8'h01

// ----------------------------------------------------------------
// security status register fields
// ----------------------------------------------------------------
`define SEC_FACTORY_BIT 0
`define SEC_LOCKDOWN_BIT 1
`define SEC_WIDE_BIT 2
`define SEC_RESERVED_BIT 3
`define SEC_CONT_PROG_BIT 4
`define SEC_PROG_FAIL_BIT 5
`define SEC_ERASE_FAIL_BIT 6
`define SEC_PROT_SEL_BIT 7
`define SEC_RESET 8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define WAKE_DELAY_NS 100000
`define WAKE_CYCLES_DEF 16'h2710

`endif

// File: verilog/pin_sync.v
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter WIDTH = 5
) (
    input wire mclk_i,
    input wire rst_i,
    input wire [WIDTH-1:0] pins_i,
    input wire [WIDTH-1:0] reset_value_i,
    output wire [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            always @(posedge mclk_i) begin
                if (rst_i) begin
                    stage1[g] <= reset_value_i[g];
                    stage2[g] <= reset_value_i[g];
                end else begin
                    stage1[g] <= pins_i[g];
                    stage2[g] <= stage1[g];
                end
            end
        end
    endgenerate
    assign sync_o = stage2;
endmodule // pin_sync

// File: verilog/byte_shift_out.v
// msb-first byte serialiser, data changes on serial clock falling edges
`timescale 1ns/1ps
module byte_shift_out (
    input wire mclk_i,
    input wire rst_i,
    input wire en_i,
    input wire fall_i,
    input wire [7:0] byte_i,
    output reg so_o,
    output reg oe_o,
    output wire take_o
);
    reg [7:0] shreg;
    reg [2:0] left;
    assign take_o = en_i & fall_i & (left == 3'h0);
    always @(posedge mclk_i) begin
        if (rst_i) begin
            so_o <= 1'b0;
            oe_o <= 1'b0;
            shreg <= 8'h00;
            left <= 3'h0;
        end else if (!en_i) begin
            so_o <= 1'b0;
            oe_o <= 1'b0;
            left <= 3'h0;
        end else begin
            oe_o <= 1'b1;
            if (fall_i) begin
                if (left == 3'h0) begin
                    so_o <= byte_i[7];
                    shreg <= {byte_i[6:0], 1'b0};
                    left <= 3'h7;
                end else begin
                    so_o <= shreg[7];
                    shreg <= {shreg[6:0], 1'b0};
                    left <= left - 3'h1;
                end
            end
        end
    end
endmodule // byte_shift_out

// File: verilog/flash_wake_id_secure.v
// wake, identification, secure-region and security-status command slice
//
// Overview of operation
// RULE_01: wake command ends on chip select rising, then part is in standby.
// RULE_02: from power-down standby follows the wake delay; host keeps select high.
// RULE_03: reset pin driven low takes the part out of power-down.
// RULE_04: legacy signature command returns one 8-bit electronic identifier.
// RULE_05: wake and signature work in power-down unless a cycle is busy.
// RULE_06: legacy identifier repeats while clocked; host stops after one whole byte.
// RULE_07: host sends id opcode, two dummy bytes, then one address byte.
// RULE_08: id bytes go out msb first on falling clock until select rises.
// RULE_09: address one puts device id first; bytes alternate while clocked.
// RULE_10: enter-secure command switches reads and programs to the otp region.
// RULE_11: in secure mode write/lock/erase commands refused; locked means reads only.
// RULE_12: exit-secure command returns access to the main array.
// RULE_13: security register readable any time, repeated while clocking continues.
// RULE_14: bit 0 reports factory lock of the secure region, read only.
// RULE_15: bit 1 set only by security write, sticks, then otp not programmable.
// RULE_16: in secure mode the main array cannot be accessed.
// RULE_17: bit 2 set by enter-wide, cleared by exit-wide or power-up.
// RULE_18: bit 4 mirrors continuous-program mode; bit 3 reads zero.
// RULE_19: bit 5 set by program failure or protected target until fail clear.
// RULE_20: bit 6 set by erase failure or protected target until fail clear.
// RULE_21: bit 7 records protection select; then all blocks locked after power-on.
// RULE_22: with protection select set, write-protect pin low protects every block.
// RULE_23: in power-down every command but wake and signature is ignored.
// RULE_24: wake only executes if select rises right after the eighth bit; code also wakes when select rises after 40 or more bits.
// RULE_25: security register shifts out msb first on falling clock edges.
`timescale 1ns/1ps
`include "flash_cmd_defines.vh"
module flash_wake_id_secure #(
    parameter [15:0] WAKE_CYCLES = `WAKE_CYCLES_DEF,
    parameter [7:0] SIGNATURE_ID = 8'h5a,
    parameter [7:0] MAKER_ID = 8'ha5,
    parameter [7:0] PART_ID = 8'h3c
) (
    input wire mclk_i,
    input wire rst_i,
    input wire cs_n_i,
    input wire sclk_i,
    input wire si_i,
    input wire reset_n_i,
    input wire wp_n_i,
    input wire busy_i,
    input wire cont_prog_i,
    input wire factory_lock_i,
    input wire nv_lockdown_i,
    input wire nv_prot_sel_i,
    input wire program_fail_i,
    input wire erase_fail_i,
    output wire so_o,
    output wire so_oe_o,
    output reg deep_power_down_o,
    output reg standby_o,
    output reg secure_mode_o,
    output reg main_array_block_o,
    output reg secure_refuse_o,
    output reg otp_read_only_o,
    output reg wide_address_o,
    output reg all_blocks_protect_o,
    output reg powerup_lock_all_o,
    output reg [7:0] security_o
);
    // ----------------------------------------------------------------
    // pin synchronisers and edges
    // ----------------------------------------------------------------
    wire [4:0] pins_s;
    wire cs_s = pins_s[0];
    wire sclk_s = pins_s[1];
    wire si_s = pins_s[2];
    wire rstn_s = pins_s[3];
    wire wpn_s = pins_s[4];
    reg cs_d;
    reg sclk_d;
    pin_sync #(.WIDTH(5)) u_sync (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .pins_i({wp_n_i, reset_n_i, si_i, sclk_i, cs_n_i}),
        .reset_value_i(5'h19),
        .sync_o(pins_s)
    );
    wire sclk_rise = sclk_s & ~sclk_d;
    wire sclk_fall = ~sclk_s & sclk_d;
    wire cs_fall = ~cs_s & cs_d;
    wire cs_rise = cs_s & ~cs_d;

    // ----------------------------------------------------------------
    // power state
    // ----------------------------------------------------------------
    localparam [1:0] ST_STANDBY = 2'h0;
    localparam [1:0] ST_POWER_DOWN = 2'h1;
    localparam [1:0] ST_WAKING = 2'h2;
    reg [1:0] state;
    reg [1:0] next_state;
    reg [15:0] wake_cnt;

    // ----------------------------------------------------------------
    // frame capture
    // ----------------------------------------------------------------
    reg frame_ok;
    reg [6:0] shreg;
    reg [5:0] bitcnt;
    reg [7:0] opcode;
    reg [7:0] addr;
    reg data_on;
    reg byte_tgl;
    wire [7:0] new_byte = {shreg, si_s};
    wire active = ~cs_s & frame_ok;
    wire op_accept = (state == ST_STANDBY) ||
        ((state == ST_POWER_DOWN) && (new_byte == `OP_WAKE_SIG) && !busy_i); // see RULE_05 RULE_23
    wire is_id = (opcode == `OP_ID_MAIN) || (opcode == `OP_ID_ALT_A) || (opcode == `OP_ID_ALT_B);
    wire at_end = cs_rise & frame_ok;
    wire exact8 = (bitcnt == `BITS_OPCODE);
    wire wake_done = at_end & (opcode == `OP_WAKE_SIG) &
        (exact8 | (bitcnt >= `BITS_SIG_MIN)); // see RULE_24 RULE_06
    wire write_ok = at_end & exact8 & (state == ST_STANDBY);
    wire nv_write_ok = write_ok & ~secure_mode_o & ~busy_i; // see RULE_11
    wire fail_clr = write_ok & (opcode == `OP_FAIL_CLEAR);

    // ----------------------------------------------------------------
    // security register state
    // ----------------------------------------------------------------
    reg nv_loaded;
    reg lockdown;
    reg prot_sel;
    reg wide;
    reg prog_fail;
    reg erase_fail;
    reg cont_prog;
    reg factory;
    wire [7:0] sec_value = {prot_sel, erase_fail, prog_fail, cont_prog,
        1'b0, wide, lockdown, factory}; // see RULE_14 RULE_18

    // ----------------------------------------------------------------
    // read-out byte selection
    // ----------------------------------------------------------------
    wire take;
    reg [7:0] tx_byte;
    always @* begin
        tx_byte = 8'h00;
        if (opcode == `OP_SEC_READ) begin
            tx_byte = sec_value; // see RULE_13 RULE_25
        end else if (opcode == `OP_WAKE_SIG) begin
            tx_byte = SIGNATURE_ID; // see RULE_04 RULE_06
        end else if (is_id) begin
            if ((addr == `ID_SWAP_ADDR) ^ byte_tgl) begin
                tx_byte = PART_ID; // see RULE_09
            end else begin
                tx_byte = MAKER_ID;
            end
        end
    end
    byte_shift_out u_tx (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .en_i(data_on & ~cs_s),
        .fall_i(sclk_fall),
        .byte_i(tx_byte),
        .so_o(so_o),
        .oe_o(so_oe_o),
        .take_o(take)
    ); // see RULE_08

    // ----------------------------------------------------------------
    // frame shifting and decode
    // ----------------------------------------------------------------
    always @(posedge mclk_i) begin
        if (rst_i) begin
            cs_d <= 1'b1;
            sclk_d <= 1'b0;
            frame_ok <= 1'b0;
            shreg <= 7'h00;
            bitcnt <= 6'h00;
            opcode <= `OP_NONE;
            addr <= 8'h00;
            data_on <= 1'b0;
            byte_tgl <= 1'b0;
        end else begin
            cs_d <= cs_s;
            sclk_d <= sclk_s;
            if (cs_fall) begin
                frame_ok <= (state != ST_WAKING); // see RULE_02
                bitcnt <= 6'h00;
                opcode <= `OP_NONE;
                data_on <= 1'b0;
                byte_tgl <= 1'b0;
            end else if (cs_s) begin
                data_on <= 1'b0;
                if (cs_rise) begin
                    frame_ok <= 1'b0;
                end
            end else if (active) begin
                if (take) begin
                    byte_tgl <= ~byte_tgl; // see RULE_09
                end
                if (sclk_rise) begin
                    shreg <= new_byte[6:0];
                    if (bitcnt != `BITS_MAX) begin
                        bitcnt <= bitcnt + 6'h01;
                    end
                    if (bitcnt == `BITS_OPCODE - 6'h01) begin
                        opcode <= op_accept ? new_byte : `OP_NONE; // see RULE_23
                        data_on <= op_accept & (new_byte == `OP_SEC_READ); // see RULE_13
                    end
                    if (bitcnt == `BITS_ID_HEADER - 6'h01) begin
                        addr <= new_byte; // see RULE_07
                        data_on <= data_on | is_id | (opcode == `OP_WAKE_SIG); // see RULE_13
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // power state machine
    // ----------------------------------------------------------------
    always @* begin
        next_state = state;
        case (state)
            ST_STANDBY: begin
                if (write_ok && (opcode == `OP_POWER_DOWN)) begin
                    next_state = ST_POWER_DOWN;
                end
            end
            ST_POWER_DOWN: begin
                if (!rstn_s) begin
                    next_state = ST_STANDBY; // see RULE_03
                end else if (wake_done) begin
                    next_state = ST_WAKING; // see RULE_01 RULE_02
                end
            end
            ST_WAKING: begin
                if (!rstn_s || (wake_cnt >= WAKE_CYCLES)) begin
                    next_state = ST_STANDBY; // see RULE_02 RULE_03
                end
            end
            default: begin
                next_state = ST_STANDBY;
            end
        endcase
    end

    always @(posedge mclk_i) begin
        if (rst_i) begin
            state <= ST_STANDBY;
            wake_cnt <= 16'h0000;
        end else begin
            state <= next_state;
            if (state == ST_WAKING) begin
                wake_cnt <= wake_cnt + 16'h0001;
            end else begin
                wake_cnt <= 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // security bits and mode flags
    // ----------------------------------------------------------------
    always @(posedge mclk_i) begin
        if (rst_i) begin
            nv_loaded <= 1'b0;
            lockdown <= 1'b0;
            prot_sel <= 1'b0;
            wide <= 1'b0;
            prog_fail <= 1'b0;
            erase_fail <= 1'b0;
            cont_prog <= 1'b0;
            factory <= 1'b0;
            secure_mode_o <= 1'b0;
            powerup_lock_all_o <= 1'b0;
        end else begin
            nv_loaded <= 1'b1;
            factory <= factory_lock_i; // see RULE_14
            cont_prog <= cont_prog_i; // see RULE_18
            powerup_lock_all_o <= ~nv_loaded & nv_prot_sel_i; // see RULE_21
            if (!nv_loaded) begin
                lockdown <= nv_lockdown_i;
                prot_sel <= nv_prot_sel_i;
            end else begin
                if (nv_write_ok && (opcode == `OP_SEC_WRITE)) begin
                    lockdown <= 1'b1; // see RULE_15
                end
                if (nv_write_ok && (opcode == `OP_PROT_SELECT)) begin
                    prot_sel <= 1'b1; // see RULE_21
                end
            end
            if (write_ok && (opcode == `OP_ENTER_WIDE)) begin
                wide <= 1'b1; // see RULE_17
            end else if (write_ok && (opcode == `OP_EXIT_WIDE)) begin
                wide <= 1'b0; // see RULE_17
            end
            prog_fail <= program_fail_i | (prog_fail & ~fail_clr); // see RULE_19
            erase_fail <= erase_fail_i | (erase_fail & ~fail_clr); // see RULE_20
            if (write_ok && (opcode == `OP_ENTER_SECURE)) begin
                secure_mode_o <= 1'b1; // see RULE_10
            end else if (write_ok && (opcode == `OP_EXIT_SECURE)) begin
                secure_mode_o <= 1'b0; // see RULE_12
            end
        end
    end

    // ----------------------------------------------------------------
    // registered status outputs
    // ----------------------------------------------------------------
    always @(posedge mclk_i) begin
        if (rst_i) begin
            deep_power_down_o <= 1'b0;
            standby_o <= 1'b1;
            main_array_block_o <= 1'b0;
            secure_refuse_o <= 1'b0;
            otp_read_only_o <= 1'b0;
            wide_address_o <= 1'b0;
            all_blocks_protect_o <= 1'b0;
            security_o <= `SEC_RESET;
        end else begin
            deep_power_down_o <= (state == ST_POWER_DOWN);
            standby_o <= (state == ST_STANDBY);
            main_array_block_o <= secure_mode_o; // see RULE_16
            secure_refuse_o <= secure_mode_o; // see RULE_11
            otp_read_only_o <= secure_mode_o & lockdown; // see RULE_11 RULE_15
            wide_address_o <= wide;
            all_blocks_protect_o <= prot_sel & ~wpn_s; // see RULE_22
            security_o <= sec_value;
        end
    end
endmodule // flash_wake_id_secure

// File: tb/flash_checker_sva.sv
// port checker for the wake, id, secure-region and status slice
`timescale 1ns/1ps
module flash_checker_sva (
    input wire mclk_i,
    input wire rst_i,
    input wire sclk_i,
    input wire wp_n_i,
    input wire cont_prog_i,
    input wire program_fail_i,
    input wire erase_fail_i,
    input wire secure_mode_o,
    input wire main_array_block_o,
    input wire secure_refuse_o,
    input wire wide_address_o,
    input wire all_blocks_protect_o,
    input wire powerup_lock_all_o,
    input wire [7:0] security_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    AST_RSVD_ZERO: assert property (!security_o[3]) else $error("reserved bit set");
    AST_CP_SET: assert property (cont_prog_i |-> ##[1:3] security_o[4])
        else $error("continuous bit missed");
    AST_CP_CLR: assert property (!cont_prog_i [*3] |-> !security_o[4])
        else $error("continuous bit stuck");
    AST_PFAIL: assert property (program_fail_i |-> ##[1:2] security_o[5])
        else $error("program fail lost");
    AST_EFAIL: assert property (erase_fail_i |-> ##[1:2] security_o[6])
        else $error("erase fail lost");
    AST_FAIL_HOLD: assert property ($fell(security_o[5]) || $fell(security_o[6]) |->
        !sclk_i && !$past(sclk_i, 2)) else $error("fail flag dropped in frame");
    AST_LOCK_STICKY: assert property (security_o[1] |=> security_o[1])
        else $error("lockdown bit cleared");
    AST_PSEL_STICKY: assert property (security_o[7] |=> security_o[7])
        else $error("protection select cleared");
    AST_MAIN_BLOCK: assert property (secure_mode_o |=> main_array_block_o)
        else $error("main array open in secure mode");
    AST_REFUSE: assert property (secure_mode_o |-> ##[0:1] secure_refuse_o)
        else $error("secure refusal missing");
    AST_WIDE: assert property (wide_address_o |-> ##[0:1] security_o[2])
        else $error("wide bit missing");
    AST_WP_ALL: assert property ((security_o[7] && !wp_n_i) [*5] |-> all_blocks_protect_o)
        else $error("write protect pin ignored");
    AST_PWRUP: assert property (powerup_lock_all_o |-> ##[0:2] security_o[7])
        else $error("power-up lock without select");
endmodule // flash_checker_sva
bind flash_wake_id_secure flash_checker_sva u_checker (
    .mclk_i(mclk_i), .rst_i(rst_i), .sclk_i(sclk_i), .wp_n_i(wp_n_i),
    .cont_prog_i(cont_prog_i), .program_fail_i(program_fail_i), .erase_fail_i(erase_fail_i),
    .secure_mode_o(secure_mode_o), .main_array_block_o(main_array_block_o),
    .secure_refuse_o(secure_refuse_o), .wide_address_o(wide_address_o),
    .all_blocks_protect_o(all_blocks_protect_o), .powerup_lock_all_o(powerup_lock_all_o),
    .security_o(security_o));

// File: tb/spi_host_model.sv
// serial host model driving select, clock and data in
`timescale 1ns/1ps
module spi_host_model (
    input wire mclk_i,
    input wire so_i,
    output logic cs_n_o = 1'b1,
    output logic sclk_o = 1'b0,
    output logic si_o = 1'b0
);
    // shifts n bits msb first, gathers data out at each rise, then idles gap cycles
    task automatic xfer(input logic [63:0] tx, input int n, input int gap,
                        output logic [63:0] rx);
        int i;
        rx = 64'h0;
        @(posedge mclk_i);
        cs_n_o <= 1'b0;
        for (i = n - 1; i >= 0; i--) begin
            si_o <= tx[i];
            repeat (8) @(posedge mclk_i);
            sclk_o <= 1'b1;
            rx = {rx[62:0], so_i};
            repeat (8) @(posedge mclk_i);
            sclk_o <= 1'b0;
        end
        repeat (8) @(posedge mclk_i);
        cs_n_o <= 1'b1;
        si_o <= ~si_o;
        repeat (gap) @(posedge mclk_i);
    endtask
endmodule // spi_host_model

// File: tb/tb.sv
// bench for the wake, id, secure-region and status slice
`timescale 1ns/1ps
module tb;
    localparam [15:0] WAKE = 16'h0014;
    localparam [7:0] SIG = 8'h5a, MK = 8'ha5, PT = 8'h3c;
    logic mclk = 1'b0, rst = 1'b1, rstn = 1'b1, wpn = 1'b1, busy = 1'b0, cp = 1'b0;
    logic fac = 1'b0, nld = 1'b0, nps = 1'b0, pf = 1'b0, ef = 1'b0;
    logic m_ps = 1'b0, m_ef = 1'b0, m_pf = 1'b0, m_wd = 1'b0, m_ld = 1'b0;
    int oe_cnt = 0, pu_cnt = 0, oe_base = 0, pu_base = 0;
    logic [63:0] rx;
    logic [7:0] op, ad;
    wire [7:0] sec;
    wire cs_n, sclk, si, so, oe, dpd, stby, smode, mab, refuse, otp_ro, wide, abp, pul;
    int n_fail = 0, n_compared = 0, i;
    spi_host_model host (.mclk_i(mclk), .so_i(so), .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si));
    flash_wake_id_secure #(.WAKE_CYCLES(WAKE), .SIGNATURE_ID(SIG), .MAKER_ID(MK), .PART_ID(PT))
    dut (.mclk_i(mclk), .rst_i(rst), .cs_n_i(cs_n), .sclk_i(sclk), .si_i(si), .reset_n_i(rstn),
        .wp_n_i(wpn), .busy_i(busy), .cont_prog_i(cp), .factory_lock_i(fac),
        .nv_lockdown_i(nld), .nv_prot_sel_i(nps), .program_fail_i(pf), .erase_fail_i(ef),
        .so_o(so), .so_oe_o(oe), .deep_power_down_o(dpd), .standby_o(stby),
        .secure_mode_o(smode), .main_array_block_o(mab), .secure_refuse_o(refuse),
        .otp_read_only_o(otp_ro), .wide_address_o(wide), .all_blocks_protect_o(abp),
        .powerup_lock_all_o(pul), .security_o(sec));
    initial forever #5 mclk = ~mclk;
    always @(posedge mclk) begin
        if (oe === 1'b1) oe_cnt <= oe_cnt + 1;
        if (pul === 1'b1) pu_cnt <= pu_cnt + 1;
    end
    function automatic logic [7:0] exp_sec();
        return {m_ps, m_ef, m_pf, cp, 1'b0, m_wd, m_ld, fac};
    endfunction
    function automatic logic [31:0] exp_id(input logic [7:0] a);
        return (a == 8'h01) ? {PT, MK, PT, MK} : {MK, PT, MK, PT};
    endfunction
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_compared++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic cmd(input logic [63:0] tx, input int n);
        host.xfer(tx, n, 12, rx);
    endtask
    task automatic rd_sec();
        int base;
        base = oe_cnt;
        host.xfer(64'h2b00000000, 40, 12, rx);
        chk("sec_serial", {4{exp_sec()}}, rx[31:0]);
        chk("so_enable", 1'b1, oe_cnt != base);
        chk("sec_reg", exp_sec(), sec);
    endtask
    task automatic report_and_stop();
        if (n_fail == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        cyc(60000);
        n_fail++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'h540d));
        cyc(3);
        rst <= 1'b0;
        cyc(5);
        for (i = 0; i < 4; i++) begin
            fac <= 1'($urandom);
            cp <= 1'($urandom);
            cyc(2);
            rd_sec();
        end
        cmd(64'hb7, 8);
        m_wd = 1'b1;
        chk("wide", 1'b1, wide);
        rd_sec();
        cmd(64'he9, 8);
        m_wd = 1'b0;
        rd_sec();
        pf <= 1'b1;
        cyc(1);
        pf <= 1'b0;
        ef <= 1'b1;
        cyc(1);
        ef <= 1'b0;
        {m_pf, m_ef} = 2'b11;
        rd_sec();
        busy <= 1'b1;
        rd_sec();
        busy <= 1'b0;
        cmd(64'h060, 9);
        rd_sec();
        cmd(64'h30, 8);
        {m_pf, m_ef} = 2'b00;
        rd_sec();
        for (i = 0; i < 6; i++) begin
            op = (i % 3 == 0) ? 8'h90 : ((i % 3 == 1) ? 8'hdf : 8'hef);
            ad = (i < 3) ? 8'h01 : 8'($urandom);
            host.xfer({op, 16'h0000, ad, 32'h0}, 64, 12, rx);
            chk("id", exp_id(ad), rx[31:0]);
        end
        host.xfer({8'hab, 40'h0}, 48, 12, rx);
        chk("signature", {SIG, SIG}, rx[15:0]);
        chk("standby", 1'b1, stby);
        cmd(64'hb1, 8);
        chk("secure_on", 3'b111, {smode, mab, refuse});
        cmd(64'h2f, 8);
        cmd(64'hc1, 8);
        chk("secure_off", 1'b0, smode);
        rd_sec();
        cmd(64'h2f, 8);
        m_ld = 1'b1;
        rd_sec();
        cmd(64'hb1, 8);
        chk("otp_ro", 1'b1, otp_ro);
        cmd(64'hc1, 8);
        cmd(64'h68, 8);
        m_ps = 1'b1;
        rd_sec();
        wpn <= 1'b0;
        cyc(6);
        chk("protect_all", 1'b1, abp);
        wpn <= 1'b1;
        cmd(64'hb9, 8);
        oe_base = oe_cnt;
        cmd(64'hb7, 8);
        host.xfer(64'h2b0000, 24, 12, rx);
        cmd(64'h156, 9);
        busy <= 1'b1;
        cmd(64'hab, 8);
        busy <= 1'b0;
        chk("pd_hold", 3'b100, {dpd, wide, oe_cnt != oe_base});
        host.xfer(64'hab, 8, 8, rx);
        chk("waking", 2'b00, {dpd, stby});
        cyc(WAKE + 6);
        chk("woken", 2'b01, {dpd, stby});
        cmd(64'hb9, 8);
        rstn <= 1'b0;
        cyc(6);
        chk("reset_pin", 2'b01, {dpd, stby});
        rstn <= 1'b1;
        cmd(64'hb7, 8);
        {nld, nps} <= 2'b11;
        pu_base = pu_cnt;
        rst <= 1'b1;
        cyc(3);
        rst <= 1'b0;
        cyc(5);
        chk("powerup_lock", 32'h1, pu_cnt - pu_base);
        rd_sec();
        report_and_stop();
    end
endmodule // tb
